// File: hw/eepe_ctrl.sv
// Purpose: EEPROM program and erase sequencer with AHB-Lite registers
// Assumes: Single-word accesses, one clock, por_n marks power-on of the nonvolatile cells
// Notes: Array and shadows are flip-flops standing in for the cells
`timescale 1ns/100ps
`include "eepe_defs.svh"
module eepe_ctrl
    import eepe_pkg::*;
#(
    parameter bit USE_CRYSTAL = 1'b0,
    parameter logic [15:0] PGM_TICKS = `EEPE_PGM_TICKS,
    parameter logic [15:0] BYTE_TICKS = `EEPE_BYTE_TICKS,
    parameter logic [15:0] BLOCK_TICKS = `EEPE_BLOCK_TICKS,
    parameter logic [15:0] BULK_TICKS = `EEPE_BULK_TICKS,
    parameter logic [7:0] NV_ACFG_INIT = `EEPE_NV_ACFG_RST,
    parameter logic [7:0] NV_DIVH_INIT = `EEPE_NV_DIVH_RST,
    parameter logic [7:0] NV_DIVL_INIT = `EEPE_NV_DIVL_RST
) (
    // Clock and resets
    input wire logic clk,
    input wire logic rst_n,
    input wire logic por_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Timebase reference pin
    input wire logic crystal_clock,
    // Analog controls
    output logic charge_pump_en,
    output logic array_disabled
);

    localparam int ARR_N = `EEPE_ARR_N;

    // Returns {valid, shadow, index} for a byte address
    function automatic logic [10:0] addr_tgt(input logic [11:0] a, input logic ok);
        logic [10:0] r;
        r = 11'h000;
        // Anything unmapped or misaligned stays zero, so it can never be captured
        if (ok && a[11] && a[1:0] == 2'b00) begin
            r = {2'b10, a[10:2]};
        end else if (ok && a == `EEPE_OFS_ACFG_NV) begin
            r = 11'h600;
        end else if (ok && a == `EEPE_OFS_DIVH_NV) begin
            r = 11'h601;
        end else if (ok && a == `EEPE_OFS_DIVL_NV) begin
            r = 11'h602;
        end
        return r;
    endfunction

    // Whether a program or erase in this mode touches array byte i
    function automatic logic op_hits(input eepe_mode_e m, input logic [8:0] i,
                                     input logic [8:0] t);
        logic h;
        h = 1'b0;
        unique case (m)
            EEPE_BYTE_PROG, EEPE_BYTE_ERASE: h = (i == t);
            EEPE_BLOCK_ERASE: h = (i[8:7] == t[8:7]);
            EEPE_BULK_ERASE: h = 1'b1;
        endcase
        return h;
    endfunction

    // Whether the block holding array byte i is write protected
    function automatic logic blk_locked(input logic [3:0] bp, input logic [8:0] i);
        return bp[i[8:7]];
    endfunction

    // Bus pipeline
    logic dp_wr;
    logic rd_act;
    logic dp_ok;
    logic [11:0] dp_addr;
    // Control register
    logic pgm;
    logic lat;
    logic auto_end;
    logic off;
    logic spare;
    eepe_mode_e mode;
    // Configuration and divider
    logic [7:0] acfg;
    logic [7:0] divh;
    logic [7:0] divl;
    logic load_pend;
    // Nonvolatile cells
    logic [7:0] mem [ARR_N];
    logic [7:0] nv_acfg;
    logic [7:0] nv_divh;
    logic [7:0] nv_divl;
    // Latch and timer
    logic cap_ok;
    eepe_tgt_t cap_tgt;
    logic [7:0] cap_data;
    logic fail;
    logic [10:0] div_cnt;
    logic [15:0] tick_cnt;
    logic xs1;
    logic xs2;
    logic xs3;
    logic xlvl;

    // Address phase and decode
    wire ap = hsel & hready & htrans[1];
    wire [10:0] tg = addr_tgt(dp_addr, dp_ok);
    wire t_ok = tg[10];
    wire [7:0] w = hwdata[7:0];
    wire hit_ctrl = dp_ok & (dp_addr == `EEPE_OFS_CTRL);
    wire hit_acfg = dp_ok & (dp_addr == `EEPE_OFS_ACFG);
    wire hit_divh = dp_ok & (dp_addr == `EEPE_OFS_DIVH);
    wire hit_divl = dp_ok & (dp_addr == `EEPE_OFS_DIVL);

    // Protection decode of the captured target
    wire cap_nv = cap_tgt[9];
    wire [8:0] cap_idx = cap_tgt[8:0];
    wire sec_on = ~acfg[`EEPE_A_SEC];
    wire bp_hit = blk_locked(acfg[3:0], cap_idx);
    wire sec_hit = sec_on & (cap_idx[8:7] == 2'b01) & (cap_idx[6:4] == 3'b111);
    wire byte_op = ~mode[1];
    // Bulk erase clears only the unprotected blocks instead of refusing outright
    wire arr_ok = byte_op ? (~bp_hit & ~sec_hit) :
                  (mode == EEPE_BLOCK_ERASE) ? (~bp_hit & ~sec_on) :
                  ~sec_on; // RULE14 RULE15
    wire nv_ok = byte_op & ((cap_idx[1:0] == 2'b00) ? ~sec_on :
                            divh[`EEPE_D_LOCK]); // RULE15 RULE23
    wire allowed = (cap_nv ? nv_ok : arr_ok) & ~off;

    // Bus-side strobes
    // Latched control writes with nothing captured are dropped; a start would pump an unknown cell
    wire ctrl_wr = dp_wr & hit_ctrl & ~(lat & ~cap_ok); // RULE11
    // Write captures freeze while the pump runs; a latched read of a cell still moves cap_tgt and sets fail
    wire cap_wr = dp_wr & lat & t_ok & ~pgm & ~off; // RULE5
    wire rd_arr = rd_act & t_ok;
    wire cap_rd = rd_arr & lat; // RULE6
    wire div_wr_ok = ~lat & divh[`EEPE_D_LOCK]; // RULE21 RULE23

    // Self timer
    wire run = pgm & auto_end;
    // With the bus clock as reference every cycle is an event
    wire ref_ev = USE_CRYSTAL ? ((xs2 == xs3) & xs2 & ~xlvl) : 1'b1;
    wire [10:0] divisor = {divh[2:0], divl};
    // Compared with >= so a divisor lowered mid-count still ends the tick
    wire tb_tick = run & ref_ev & ((div_cnt + 11'h001) >= divisor); // RULE20
    wire [15:0] tick_goal = (mode == EEPE_BYTE_PROG) ? PGM_TICKS :
                            (mode == EEPE_BYTE_ERASE) ? BYTE_TICKS :
                            (mode == EEPE_BLOCK_ERASE) ? BLOCK_TICKS :
                            BULK_TICKS; // RULE24
    // The hardware clear wins over a software write in the same cycle
    wire done = run & (tick_cnt >= tick_goal); // RULE4

    // Control register next values
    wire set_pgm = w[`EEPE_C_PGM] & lat & cap_ok; // RULE7
    wire next_pgm = done ? 1'b0 :
                    ctrl_wr ? (w[`EEPE_C_PGM] & (pgm | set_pgm)) : pgm;
    // The latch outlives program enable so the high voltage can decay first
    wire next_lat = ctrl_wr ? (w[`EEPE_C_LAT] | pgm) : lat; // RULE9 RULE10
    wire pgm_rise = ~pgm & next_pgm;
    wire op_go = pgm & ~next_pgm & ~fail & cap_ok & allowed; // RULE8
    wire op_prog = (mode == EEPE_BYTE_PROG);
    // Programming only clears bits; erase returns the byte to all ones
    wire [7:0] nv_new_acfg = op_prog ? (nv_acfg & cap_data) : 8'hFF;
    wire [7:0] nv_new_divh = op_prog ? (nv_divh & cap_data) : 8'hFF;
    wire [7:0] nv_new_divl = op_prog ? (nv_divl & cap_data) : 8'hFF;

    // Read data selection
    wire [7:0] ctrl_rd = {spare, 1'b0, off, mode, lat, auto_end, pgm};
    wire [7:0] cell_rd = off ? 8'h00 : lat ? cap_data :
                         ~tg[9] ? mem[tg[8:0]] :
                         (tg[1:0] == 2'b00) ? nv_acfg :
                         tg[0] ? nv_divh : nv_divl; // RULE6 RULE17
    wire [7:0] rd_val = t_ok ? cell_rd :
                        hit_ctrl ? ctrl_rd :
                        hit_acfg ? acfg :
                        hit_divh ? divh :
                        hit_divl ? divl : 8'h00;

    // Writes finish one cycle late and reads wait one cycle, so a read sees every write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dp_wr <= 1'b0;
            rd_act <= 1'b0;
            dp_ok <= 1'b0;
            dp_addr <= 12'h000;
            hreadyout <= 1'b1;
        end else begin
            dp_wr <= ap & hwrite;
            rd_act <= ap & ~hwrite;
            hreadyout <= ~(ap & ~hwrite);
            if (ap) begin
                dp_addr <= haddr[11:0];
                dp_ok <= (haddr[31:12] == 20'h0_0000);
            end
        end
    end

    // Upper lanes read zero: every register is a single byte
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
            if (rd_act) begin
                hrdata <= {24'h00_0000, rd_val};
            end
        end
    end

    // Control register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pgm <= 1'b0;
            lat <= 1'b0;
            auto_end <= 1'b0;
            off <= 1'b0;
            spare <= 1'b0;
            mode <= EEPE_BYTE_PROG;
        end else begin
            pgm <= next_pgm;
            lat <= next_lat;
            // Mode may change mid-cycle; software keeps it steady while program enable is set
            if (ctrl_wr) begin
                auto_end <= w[`EEPE_C_AUTO];
                off <= w[`EEPE_C_OFF]; // RULE17
                spare <= w[`EEPE_C_SPARE];
                mode <= eepe_mode_e'(w[`EEPE_C_RHI:`EEPE_C_RLO]); // RULE12
            end
        end
    end

    // Address and data latch; fail marks a cell read during a running cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_ok <= 1'b0;
            cap_tgt <= 10'h000;
            cap_data <= 8'hFF;
            fail <= 1'b0;
        end else begin
            cap_ok <= next_lat & (cap_ok | cap_wr);
            if (cap_wr | cap_rd) begin
                cap_tgt <= tg[9:0];
            end
            if (cap_wr) begin
                cap_data <= w;
            end
            if (rd_arr & pgm) begin
                fail <= 1'b1; // RULE8
            end else if (pgm_rise) begin
                fail <= 1'b0;
            end
        end
    end

    // Volatile configuration; the copy from shadows takes one edge after reset release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            load_pend <= 1'b1;
            acfg <= 8'h00;
            divh <= 8'h00;
            divl <= 8'h00;
        end else if (load_pend) begin
            load_pend <= 1'b0;
            acfg <= nv_acfg; // RULE19
            divh <= nv_divh; // RULE22
            divl <= nv_divl; // RULE22
        end else begin
            if (dp_wr & hit_acfg) begin
                acfg[7:5] <= w[7:5];
                acfg[`EEPE_A_SEC] <= acfg[`EEPE_A_SEC] & w[`EEPE_A_SEC]; // RULE16
            end else if (rd_act & ~lat & t_ok & tg[9] & (tg[1:0] == 2'b00)) begin
                acfg[3:0] <= nv_acfg[3:0];
                acfg[`EEPE_A_SEC] <= acfg[`EEPE_A_SEC] & nv_acfg[`EEPE_A_SEC]; // RULE16
            end
            if (dp_wr & hit_divh & div_wr_ok) begin
                divh <= {w[7], 4'h0, w[2:0]}; // RULE21
            end
            if (dp_wr & hit_divl & div_wr_ok) begin
                divl <= w; // RULE21
            end
        end
    end

    // Array cells survive rst_n; only power-on clears them to the erased state
    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            for (int i = 0; i < ARR_N; i++) begin
                mem[i] <= 8'hFF;
            end
        end else if (op_go & ~cap_nv) begin
            for (int i = 0; i < ARR_N; i++) begin
                if (op_hits(mode, 9'(i), cap_idx) && !blk_locked(acfg[3:0], 9'(i))) begin // RULE14
                    mem[i] <= op_prog ? (mem[i] & cap_data) : 8'hFF; // RULE13
                end
            end
        end
    end

    // Shadow bytes, programmed and erased like array bytes
    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            nv_acfg <= NV_ACFG_INIT;
            nv_divh <= NV_DIVH_INIT;
            nv_divl <= NV_DIVL_INIT;
        end else if (op_go & cap_nv) begin
            if (cap_idx[1:0] == 2'b00) begin
                nv_acfg <= nv_new_acfg;
            end
            if (cap_idx[1:0] == 2'b01) begin
                nv_divh <= nv_new_divh; // RULE22
            end
            if (cap_idx[1:0] == 2'b10) begin
                nv_divl <= nv_new_divl; // RULE22
            end
        end
    end

    // Reference pin synchroniser; a rising edge counts once stages two and three agree high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xs1 <= 1'b0;
            xs2 <= 1'b0;
            xs3 <= 1'b0;
            xlvl <= 1'b0;
        end else begin
            xs1 <= crystal_clock;
            xs2 <= xs1;
            xs3 <= xs2;
            if (xs2 == xs3) begin
                xlvl <= xs2;
            end
        end
    end

    // Timebase divider and tick counter, idle outside a self-timed cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= 11'h000;
            tick_cnt <= 16'h0000;
        end else if (!run) begin
            div_cnt <= 11'h000;
            tick_cnt <= 16'h0000;
        end else begin
            if (tb_tick) begin
                div_cnt <= 11'h000; // RULE20
                tick_cnt <= tick_cnt + 16'h0001; // RULE24
            end else if (ref_ev) begin
                div_cnt <= div_cnt + 11'h001;
            end
        end
    end

    // Pump only for a permitted, fully latched cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            charge_pump_en <= 1'b0;
            array_disabled <= 1'b0;
        end else begin
            charge_pump_en <= next_pgm & next_lat & cap_ok & allowed; // RULE18 RULE14
            array_disabled <= ctrl_wr ? w[`EEPE_C_OFF] : off; // RULE17
        end
    end

endmodule

// File: hw/eepe_defs.svh
// Purpose: Offsets, bit positions, reset values and timing counts of the EEPROM control block
// Assumes: AHB-Lite word map, 8-bit registers in the low byte lane
// Notes: How it works is listed below
//
// How it works
// RULE1: Software selects byte program, latches, writes, starts
// RULE2: Software times program, clears, waits, unlatches
// RULE3: Software times erase per mode, then unlatches
// RULE4: Self-timed mode clears program enable automatically
// RULE5: Latch captures only valid array writes, last wins
// RULE6: Latched reads return data, capture read address
// RULE7: Program enable needs latch and captured address
// RULE8: Reads during a cycle spoil the operation
// RULE9: Clearing both bits clears program enable only
// RULE10: Latch cannot clear while program enable set
// RULE11: After latching, control writes need a capture
// RULE12: Mode bits decode program, byte, block, bulk
// RULE13: Erase acts on byte, block or array
// RULE14: Protected blocks refuse program and erase
// RULE15: Secured range locked; block and bulk blocked
// RULE16: Range security enable is write once
// RULE17: Power-down bit disables the array
// RULE18: Pump runs only with enable, latch, capture
// RULE19: Reset loads configuration from its shadow
// RULE20: Divisor divides reference into 35 us ticks
// RULE21: Divisor writable only unlatched and unlocked
// RULE22: Reset loads divisor from its shadow bytes
// RULE23: Divider lock freezes divisor and shadows
// RULE24: Self timer counts timebase ticks per mode
`ifndef EEPE_DEFS_SVH
`define EEPE_DEFS_SVH

`define EEPE_OFS_CTRL 12'h000
`define EEPE_OFS_ACFG 12'h004
`define EEPE_OFS_ACFG_NV 12'h008
`define EEPE_OFS_DIVH 12'h00C
`define EEPE_OFS_DIVL 12'h010
`define EEPE_OFS_DIVH_NV 12'h014
`define EEPE_OFS_DIVL_NV 12'h018
`define EEPE_ARR_N 512

`define EEPE_C_PGM 0
`define EEPE_C_AUTO 1
`define EEPE_C_LAT 2
`define EEPE_C_RLO 3
`define EEPE_C_RHI 4
`define EEPE_C_OFF 5
`define EEPE_C_SPARE 7
`define EEPE_A_SEC 4
`define EEPE_D_LOCK 7

`define EEPE_NV_ACFG_RST 8'hF0
`define EEPE_TB_US 35
`define EEPE_CLK_KHZ 25000
`define EEPE_TB_DIV ((`EEPE_CLK_KHZ * `EEPE_TB_US + 500) / 1000)
`define EEPE_NV_DIVH_RST {1'b1, 4'h0, 3'(`EEPE_TB_DIV >> 8)}
`define EEPE_NV_DIVL_RST 8'(`EEPE_TB_DIV)
`define EEPE_PGM_TICKS 16'h0100
`define EEPE_BYTE_TICKS 16'h0100
`define EEPE_BLOCK_TICKS 16'h0200
`define EEPE_BULK_TICKS 16'h0300

`endif

// File: hw/eepe_pkg.sv
// Purpose: Types shared by the EEPROM control block
// Assumes: Nothing beyond the defines header
// Notes: Mode codes match the mode-select bits
package eepe_pkg;
    typedef enum logic [1:0] {
        EEPE_BYTE_PROG = 2'b00,
        EEPE_BYTE_ERASE = 2'b01,
        EEPE_BLOCK_ERASE = 2'b10,
        EEPE_BULK_ERASE = 2'b11
    } eepe_mode_e;
    // Bit 9 marks a shadow byte, bits 8:0 the byte index
    typedef logic [9:0] eepe_tgt_t;
endpackage

// File: tb/eepe_ctrl_properties.sv
// Purpose: Bus and analog-control properties of the EEPROM control block
// Assumes: hready is tied to hreadyout outside the block
// Notes: Sees only the top-level ports
`timescale 1ns/100ps
module eepe_ctrl_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // AHB-Lite
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Analog controls
    input wire logic charge_pump_en,
    input wire logic array_disabled
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic ctrl_dp;
    wire taken = hsel && hready && htrans[1];
    wire rd_taken = taken && !hwrite;
    wire ctrl_wr = taken && hwrite && haddr == 32'h0000_0000;
    // Marks the data phase of a control write so hwdata can be tied to it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_dp <= 1'b0;
        end else if (hready) begin
            ctrl_dp <= ctrl_wr;
        end
    end
    sequence s_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    sequence s_data_ready;
        ##2 hreadyout;
    endsequence
    property p_okay;
        hresp == 1'b0;
    endproperty
    a_okay: assert property (p_okay) else $error("response not OKAY");
    property p_rd_wait;
        rd_taken |=> s_wait;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait not one cycle");
    property p_wr_nowait;
        taken && hwrite |=> hreadyout;
    endproperty
    a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
    property p_upper;
        rd_taken |-> s_data_ready ##0 hrdata[31:8] == 24'h00_0000;
    endproperty
    a_upper: assert property (p_upper) else $error("upper read lanes not zero");
    property p_unmapped;
        rd_taken && haddr[31:12] != 20'h0_0000 |-> ##2 hrdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_divh_zero;
        rd_taken && haddr == 32'h0000_000C |-> ##2 hrdata[6:3] == 4'h0;
    endproperty
    a_divh_zero: assert property (p_divh_zero) else $error("divider high spare bits set");
    property p_pump_rise;
        $rose(charge_pump_en) |-> $past(ctrl_dp && hwdata[0] && hwdata[2]);
    endproperty
    a_pump_rise: assert property (p_pump_rise) else $error("pump without start");
    property p_off_rise;
        $rose(array_disabled) |-> $past(ctrl_dp && hwdata[5]);
    endproperty
    a_off_rise: assert property (p_off_rise) else $error("array off without write");
endmodule
bind eepe_ctrl eepe_ctrl_properties eepe_ctrl_properties_i (.clk(clk), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .charge_pump_en(charge_pump_en), .array_disabled(array_disabled));

// File: tb/eepe_ctrl_tb_top.sv
// Purpose: Self-checking bench for the EEPROM control block
// Assumes: hready tied to hreadyout, timer goals shortened to 4 ticks
// Notes: Reads queue their expectation; a monitor compares at the data phase
`timescale 1ns/100ps
module eepe_ctrl_tb_top
    import eepe_pkg::*;
();
    localparam logic [31:0] CTRL = 32'h0000_0000;
    localparam logic [31:0] ACFG = 32'h0000_0004;
    localparam logic [31:0] DIVH = 32'h0000_000C;
    localparam logic [31:0] DIVL = 32'h0000_0010;
    logic clk, rst_n, por_n, hsel, hwrite, xtal, hreadyout, hresp, pump, off, rd_dp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [32:0] exp_q[$];
    logic [7:0] d1, d2;
    int mismatches, checks_done, test_n;
    eepe_ctrl #(.PGM_TICKS(16'h0004), .BYTE_TICKS(16'h0004), .BLOCK_TICKS(16'h0004),
        .BULK_TICKS(16'h0004), .NV_ACFG_INIT(8'hF4)) eepe_ctrl_i (
        .clk(clk), .rst_n(rst_n), .por_n(por_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .crystal_clock(xtal), .charge_pump_en(pump), .array_disabled(off));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    function automatic logic [31:0] aa(input logic [8:0] i);
        return 32'h0000_0800 + {21'h00_0000, i, 2'b00};
    endfunction
    task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d,
        output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= a;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {24'h00_0000, d};
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [31:0] a, input logic [7:0] e, input logic c,
        output logic [31:0] r);
        exp_q.push_back({c, 24'h00_0000, e});
        xfer(1'b0, a, 8'h00, r);
    endtask
    task automatic chk(input logic [31:0] a, input logic [7:0] e);
        logic [31:0] r;
        rd(a, e, 1'b1, r);
    endtask
    task automatic chk_pin(input logic v, input logic e);
        checks_done++;
        if (v !== e) begin
            mismatches++;
            $display("Error %0t: pin %b expected %b", $time, v, e);
        end
    endtask
    // Self-timed operation; polling stops after a bounded number of reads
    task automatic op(input eepe_mode_e m, input logic [8:0] i, input logic [7:0] d);
        logic [31:0] r;
        int n;
        wr(CTRL, {3'b000, m, 3'b110});
        wr(aa(i), d);
        wr(CTRL, {3'b000, m, 3'b111});
        n = 0;
        r = 32'h0000_0001;
        while (r[0] !== 1'b0 && n < 100) begin
            rd(CTRL, 8'h00, 1'b0, r);
            n++;
        end
        chk(CTRL, {3'b000, m, 3'b110});
        wr(CTRL, 8'h00);
    endtask
    task automatic next_test();
        test_n++;
        $display("test %0d finished", test_n);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        logic [32:0] e;
        if (rd_dp === 1'b1 && hreadyout === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            if (e[32]) begin
                checks_done++;
                if (hrdata !== e[31:0]) begin
                    mismatches++;
                    $display("Error %0t: read %h expected %h", $time, hrdata, e[31:0]);
                end
            end
        end
        if (hreadyout === 1'b1) begin
            rd_dp <= hsel && htrans[1] && !hwrite;
        end
    end
    initial begin
        repeat (30000) @(posedge clk);
        mismatches++;
        $display("Error %0t: watchdog expired", $time);
        report_and_stop();
    end
    initial begin
        {rst_n, por_n, hsel, hwrite, xtal} = '0;
        {htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        void'($urandom(21));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        chk(CTRL, 8'h00);
        chk(ACFG, 8'hF4);
        chk(DIVH, 8'h83);
        chk(DIVL, 8'h6B);
        chk(32'h0000_1000, 8'h00);
        wr(CTRL, 8'h01);
        chk(CTRL, 8'h00);
        wr(DIVL, 8'h02);
        wr(DIVH, 8'h80);
        chk(DIVH, 8'h80);
        wr(CTRL, 8'h04);
        wr(DIVL, 8'h05);
        chk(DIVL, 8'h02);
        next_test();
        wr(CTRL, 8'h25);
        chk(CTRL, 8'h04);
        d1 = 8'($urandom());
        d2 = 8'($urandom());
        wr(aa(9'h005), d1);
        wr(aa(9'h006), d2);
        chk(aa(9'h009), d2);
        wr(CTRL, 8'h05);
        repeat (20) @(posedge clk);
        wr(CTRL, 8'h01);
        chk(CTRL, 8'h05);
        wr(CTRL, 8'h00);
        chk(CTRL, 8'h04);
        wr(CTRL, 8'h00);
        chk(CTRL, 8'h00);
        chk(aa(9'h009), d2);
        chk(aa(9'h006), 8'hFF);
        next_test();
        op(EEPE_BYTE_ERASE, 9'h009, 8'h00);
        chk(aa(9'h009), 8'hFF);
        op(EEPE_BYTE_PROG, 9'h002, 8'h0F);
        op(EEPE_BYTE_PROG, 9'h07F, 8'h3C);
        chk(aa(9'h002), 8'h0F);
        op(EEPE_BLOCK_ERASE, 9'h040, 8'h00);
        chk(aa(9'h07F), 8'hFF);
        op(EEPE_BYTE_PROG, 9'h080, 8'h55);
        op(EEPE_BULK_ERASE, 9'h000, 8'h00);
        chk(aa(9'h080), 8'hFF);
        op(EEPE_BYTE_PROG, 9'h103, 8'h00);
        chk(aa(9'h103), 8'hFF);
        next_test();
        wr(ACFG, 8'hE0);
        wr(ACFG, 8'hF0);
        chk(ACFG, 8'hE4);
        op(EEPE_BYTE_PROG, 9'h0F5, 8'h00);
        chk(aa(9'h0F5), 8'hFF);
        op(EEPE_BYTE_PROG, 9'h002, 8'h0F);
        op(EEPE_BLOCK_ERASE, 9'h002, 8'h00);
        chk(aa(9'h002), 8'h0F);
        wr(CTRL, 8'h20);
        chk(aa(9'h002), 8'h00);
        chk_pin(off, 1'b1);
        wr(CTRL, 8'h00);
        @(posedge clk);
        chk_pin(off, 1'b0);
        next_test();
        wr(CTRL, 8'h0C);
        wr(aa(9'h002), 8'h00);
        wr(CTRL, 8'h0D);
        repeat (20) @(posedge clk);
        chk_pin(pump, 1'b1);
        wr(CTRL, 8'h0C);
        repeat (4) @(posedge clk);
        chk_pin(pump, 1'b0);
        wr(CTRL, 8'h00);
        chk(aa(9'h002), 8'hFF);
        wr(CTRL, 8'h04);
        wr(aa(9'h010), 8'h00);
        wr(CTRL, 8'h05);
        chk(aa(9'h010), 8'h00);
        wr(CTRL, 8'h04);
        wr(CTRL, 8'h00);
        chk(aa(9'h010), 8'hFF);
        next_test();
        wr(DIVH, 8'h00);
        wr(DIVL, 8'h09);
        wr(DIVH, 8'h80);
        chk(DIVH, 8'h00);
        chk(DIVL, 8'h02);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        chk(DIVH, 8'h83);
        chk(ACFG, 8'hF4);
        next_test();
        report_and_stop();
    end
endmodule
